// *** verilog/acspi_top.sv ***
// Contract
// RL1 - sample mosi on rising serial clock
// RL2 - drive miso on falling serial clock
// RL3 - most significant bit first, both ways
// RL4 - select fall starts; first eight bits command
// RL5 - select rise ends transfer, clears counter, command
// RL6 - bad command: ignore input, miso released
// RL7 - first answer bit on next falling edge
// RL8 - answer shifts out alongside input data
// RL9 - master keeps serial clock at most 500 kHz; test master runs it at 6.25 MHz
// RL10 - decode measure and both self test codes
// RL11 - decode temperature and both acceleration reads
// RL12 - measure after reset; measure ends self test
// RL13 - self test per channel until measure
// RL14 - master never enables both self tests
// RL15 - temperature reload every period unless selected
// RL16 - acceleration reload every period unless selected
// RL17 - master idles select before data reads
// RL18 - acceleration read returns eleven bits
// RL19 - temperature read returns eight, input ignored
// RL20 - master limits acceleration read rate
// RL21 - readings in range; failures force outside
// RL22 - parity error reloads; repeat forces low
// RL23 - self test drives channel reading to maximum
// RL24 - master idles select between transactions
// RL25 - undefined command codes treated as invalid
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "acspi_cfg.svh"

module acspi_top
    import acspi_pkg::*;
#(
    parameter int unsigned RELOAD_CYCLES = `ACSPI_RELOAD_NS / `ACSPI_CLK_NS,
    parameter logic [`ACSPI_CAL_W-1:0] CAL_NVM = `ACSPI_CAL_NVM
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sck_i,
    input wire logic select_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic selftest_pin_x_i,
    input wire logic selftest_pin_y_i,
    input wire logic [`ACSPI_ADDR_W-1:0] reg_addr_i,
    input wire logic [`ACSPI_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`ACSPI_DATA_W-1:0] reg_rdata_o,
    output logic selftest_x_o,
    output logic selftest_y_o
);

    localparam logic [4:0] PIN_RST = 5'h02;

    logic [1:0] rst_pipe_q;
    logic rst_n;
    logic [4:0] pins_raw;
    logic [4:0] pins_s;
    logic s_sck;
    logic s_sel_n;
    logic s_mosi;
    logic s_pin_x;
    logic s_pin_y;
    logic sck_rise;
    logic sck_fall;
    logic sel_fall;
    logic sel_rise;
    logic reload_tick;
    logic [`ACSPI_CMD_W-1:0] cmd_full;
    logic st_x_on;
    logic st_y_on;

    acspi_regs_t q;
    acspi_regs_t d;

    // reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_pipe_q <= 2'b00;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_q[1];

    assign pins_raw = {selftest_pin_y_i, selftest_pin_x_i, mosi_i, select_n_i, sck_i};

    acspi_sync #(
        .W(5),
        .RST_VAL(PIN_RST)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    assign s_sck = pins_s[0];
    assign s_sel_n = pins_s[1];
    assign s_mosi = pins_s[2];
    assign s_pin_x = pins_s[3];
    assign s_pin_y = pins_s[4];

    acspi_tick #(
        .CYCLES(RELOAD_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .tick_o(reload_tick)
    );

    // edge detection on the synchronised copies
    assign sck_rise = s_sck & ~q.sck_prev;
    assign sck_fall = ~s_sck & q.sck_prev;
    assign sel_fall = ~s_sel_n & q.sel_prev;
    assign sel_rise = s_sel_n & ~q.sel_prev;

    // command as it stands after the bit now being sampled
    assign cmd_full = {q.cmd[`ACSPI_CMD_W-2:0], s_mosi};

    // self test by command or by pin
    assign st_x_on = (q.mode == ACSPI_STX) | s_pin_x; // [RL13]
    assign st_y_on = (q.mode == ACSPI_STY) | s_pin_y; // [RL13]

    // value loaded into an acceleration data register
    function automatic logic [`ACSPI_ACC_W-1:0] acspi_acc_val(
        input logic [`ACSPI_ACC_W-1:0] smp,
        input logic st_on,
        input logic link_f,
        input logic mem_f
    );
        logic [`ACSPI_ACC_W-1:0] v;
        v = smp;
        if (mem_f) begin
            v = `ACSPI_ACC_FAIL_LO; // [RL22]
        end else if (link_f) begin
            v = `ACSPI_ACC_FAIL_HI; // [RL21]
        end else if (st_on) begin
            v = `ACSPI_ACC_MAX; // [RL23]
        end else if (smp < `ACSPI_ACC_MIN) begin
            v = `ACSPI_ACC_MIN; // [RL21]
        end else if (smp > `ACSPI_ACC_MAX) begin
            v = `ACSPI_ACC_MAX; // [RL21]
        end
        return v;
    endfunction : acspi_acc_val

    always_comb begin
        d = q;
        d.rdata = '0;
        d.sck_prev = s_sck;
        d.sel_prev = s_sel_n;

        // serial side
        if (sel_fall) begin
            d.st = ACSPI_CMD; // [RL4]
            d.cnt = '0;
            d.cmd = '0;
            d.miso = 1'b0;
            d.miso_oe = 1'b0;
            d.xfer_cnt = q.xfer_cnt + `ACSPI_XCNT_ONE;
        end else if (sel_rise) begin
            d.st = ACSPI_IDLE; // [RL5]
            d.cnt = '0; // [RL5]
            d.cmd = '0; // [RL5]
            d.miso = 1'b0;
            d.miso_oe = 1'b0;
        end else if (!s_sel_n) begin
            unique case (q.st)
                ACSPI_IDLE: begin
                    // selected before reset ended: wait for a fresh fall
                    d.st = ACSPI_IDLE;
                end
                ACSPI_CMD: begin
                    if (sck_rise) begin
                        d.cmd = cmd_full; // [RL1] [RL3]
                        d.cnt = q.cnt + `ACSPI_CNT_ONE;
                        if (q.cnt == `ACSPI_CMD_LAST) begin
                            d.last_cmd = cmd_full; // [RL4]
                            unique case (cmd_full)
                                `ACSPI_CMD_MEASURE_CMD: begin
                                    d.mode = ACSPI_MEASURE_CMD; // [RL10] [RL12]
                                    d.st = ACSPI_HOLD;
                                end
                                `ACSPI_CMD_STX: begin
                                    d.mode = ACSPI_STX; // [RL10] [RL13]
                                    d.st = ACSPI_HOLD;
                                end
                                `ACSPI_CMD_STY: begin
                                    d.mode = ACSPI_STY; // [RL10] [RL13]
                                    d.st = ACSPI_HOLD;
                                end
                                `ACSPI_CMD_RTEMP: begin
                                    d.resp = {q.dat_t, `ACSPI_TEMP_PAD'(0)}; // [RL11] [RL19]
                                    d.st = ACSPI_DATA;
                                end
                                `ACSPI_CMD_RDX: begin
                                    d.resp = q.dat_x; // [RL11] [RL18]
                                    d.st = ACSPI_DATA;
                                end
                                `ACSPI_CMD_RDY: begin
                                    d.resp = q.dat_y; // [RL11] [RL18]
                                    d.st = ACSPI_DATA;
                                end
                                default: begin
                                    d.st = ACSPI_HOLD; // [RL6] [RL25]
                                    d.bad_cnt = q.bad_cnt + `ACSPI_XCNT_ONE;
                                end
                            endcase
                        end
                    end
                end
                ACSPI_DATA: begin
                    // input bits during a read are ignored
                    if (sck_fall) begin
                        d.miso = q.resp[`ACSPI_ACC_W-1]; // [RL2] [RL3] [RL7] [RL8]
                        d.resp = {q.resp[`ACSPI_ACC_W-2:0], 1'b0}; // [RL19]
                        d.miso_oe = 1'b1;
                    end
                end
                ACSPI_HOLD: begin
                    d.miso_oe = 1'b0; // [RL6]
                end
            endcase
        end

        // self test outputs
        d.st_x = st_x_on;
        d.st_y = st_y_on;

        // register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                `ACSPI_OFS_CTRL: d.link_fault = reg_wdata_i[`ACSPI_CTRL_LINK_BIT];
                `ACSPI_OFS_CAL: d.cal = reg_wdata_i[`ACSPI_CAL_W-1:0];
                `ACSPI_OFS_SMP_X: d.smp_x = reg_wdata_i[`ACSPI_ACC_W-1:0];
                `ACSPI_OFS_SMP_Y: d.smp_y = reg_wdata_i[`ACSPI_ACC_W-1:0];
                `ACSPI_OFS_SMP_T: d.smp_t = reg_wdata_i[`ACSPI_TEMP_W-1:0];
                default: d.link_fault = q.link_fault;
            endcase
        end

        // continuous parity check of the calibration word
        if (^q.cal) begin
            if (!q.cal_reloaded) begin
                d.cal = CAL_NVM; // [RL22]
                d.cal_reloaded = 1'b1;
            end else begin
                d.mem_fault = 1'b1; // [RL22]
            end
        end

        // periodic reload, held off while selected
        if (reload_tick && s_sel_n) begin
            d.dat_t = q.smp_t; // [RL15]
            d.dat_x = acspi_acc_val(q.smp_x, st_x_on, q.link_fault, q.mem_fault); // [RL16]
            d.dat_y = acspi_acc_val(q.smp_y, st_y_on, q.link_fault, q.mem_fault); // [RL16]
        end

        // register reads, data in the following cycle only
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ACSPI_OFS_CTRL: d.rdata = `ACSPI_DATA_W'(q.link_fault);
                `ACSPI_OFS_CAL: d.rdata = `ACSPI_DATA_W'(q.cal);
                `ACSPI_OFS_SMP_X: d.rdata = `ACSPI_DATA_W'(q.smp_x);
                `ACSPI_OFS_SMP_Y: d.rdata = `ACSPI_DATA_W'(q.smp_y);
                `ACSPI_OFS_SMP_T: d.rdata = `ACSPI_DATA_W'(q.smp_t);
                `ACSPI_OFS_STATUS: begin
                    d.rdata = `ACSPI_DATA_W'({q.st_y, q.st_x, q.last_cmd, q.st, ~q.sel_prev,
                                              q.link_fault, q.cal_reloaded, q.mem_fault, q.mode});
                end
                `ACSPI_OFS_DAT_X: d.rdata = `ACSPI_DATA_W'(q.dat_x);
                `ACSPI_OFS_DAT_Y: d.rdata = `ACSPI_DATA_W'(q.dat_y);
                `ACSPI_OFS_DAT_T: d.rdata = `ACSPI_DATA_W'(q.dat_t);
                `ACSPI_OFS_COUNT: d.rdata = {q.bad_cnt, q.xfer_cnt};
                default: d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= ACSPI_IDLE;
            q.mode <= ACSPI_MEASURE_CMD; // [RL12]
            q.sck_prev <= 1'b0;
            q.sel_prev <= 1'b1;
            q.cal <= CAL_NVM;
        end else begin
            q <= d;
        end
    end

    assign miso_o = q.miso;
    assign miso_oe_o = q.miso_oe;
    assign reg_rdata_o = q.rdata;
    assign selftest_x_o = q.st_x;
    assign selftest_y_o = q.st_y;

endmodule : acspi_top

// *** verilog/acspi_cfg.svh ***
`ifndef ACSPI_CFG_SVH
`define ACSPI_CFG_SVH

// command codes
`define ACSPI_CMD_MEASURE_CMD 8'h00
`define ACSPI_CMD_RTEMP 8'h08
`define ACSPI_CMD_STX 8'h0E
`define ACSPI_CMD_STY 8'h0F
`define ACSPI_CMD_RDX 8'h10
`define ACSPI_CMD_RDY 8'h11

// widths
`define ACSPI_CMD_W 8
`define ACSPI_ACC_W 11
`define ACSPI_TEMP_W 8
`define ACSPI_TEMP_PAD 3
`define ACSPI_CNT_W 4
`define ACSPI_CAL_W 17
`define ACSPI_ADDR_W 8
`define ACSPI_DATA_W 32
`define ACSPI_XCNT_W 16

// counter values
`define ACSPI_CNT_ONE 4'h1
`define ACSPI_CMD_LAST 4'h7
`define ACSPI_XCNT_ONE 16'h0001

// reading limits and forced values
`define ACSPI_ACC_MIN 11'h066
`define ACSPI_ACC_MAX 11'h799
`define ACSPI_ACC_FAIL_LO 11'h000
`define ACSPI_ACC_FAIL_HI 11'h7FF

// calibration word reset copy, even parity over all bits
`define ACSPI_CAL_NVM 17'h0_0000

// register offsets
`define ACSPI_OFS_CTRL 8'h00
`define ACSPI_OFS_CAL 8'h04
`define ACSPI_OFS_SMP_X 8'h08
`define ACSPI_OFS_SMP_Y 8'h0C
`define ACSPI_OFS_SMP_T 8'h10
`define ACSPI_OFS_STATUS 8'h14
`define ACSPI_OFS_DAT_X 8'h18
`define ACSPI_OFS_DAT_Y 8'h1C
`define ACSPI_OFS_DAT_T 8'h20
`define ACSPI_OFS_COUNT 8'h24

// field positions
`define ACSPI_CTRL_LINK_BIT 0

// timing
`define ACSPI_RELOAD_NS 150000
`define ACSPI_CLK_NS 10

`endif

// *** verilog/acspi_pkg.sv ***
`include "acspi_cfg.svh"

package acspi_pkg;

    typedef enum logic [1:0] {
        ACSPI_IDLE = 2'b00,
        ACSPI_CMD = 2'b01,
        ACSPI_DATA = 2'b11,
        ACSPI_HOLD = 2'b10
    } acspi_state_t;

    typedef enum logic [1:0] {
        ACSPI_MEASURE_CMD = 2'b00,
        ACSPI_STX = 2'b01,
        ACSPI_STY = 2'b11
    } acspi_mode_t;

    typedef struct packed {
        acspi_state_t st;
        logic [`ACSPI_CMD_W-1:0] cmd;
        logic [`ACSPI_CNT_W-1:0] cnt;
        logic [`ACSPI_ACC_W-1:0] resp;
        logic miso;
        logic miso_oe;
        logic sck_prev;
        logic sel_prev;
        acspi_mode_t mode;
        logic st_x;
        logic st_y;
        logic link_fault;
        logic [`ACSPI_CAL_W-1:0] cal;
        logic cal_reloaded;
        logic mem_fault;
        logic [`ACSPI_ACC_W-1:0] smp_x;
        logic [`ACSPI_ACC_W-1:0] smp_y;
        logic [`ACSPI_TEMP_W-1:0] smp_t;
        logic [`ACSPI_ACC_W-1:0] dat_x;
        logic [`ACSPI_ACC_W-1:0] dat_y;
        logic [`ACSPI_TEMP_W-1:0] dat_t;
        logic [`ACSPI_CMD_W-1:0] last_cmd;
        logic [`ACSPI_XCNT_W-1:0] xfer_cnt;
        logic [`ACSPI_XCNT_W-1:0] bad_cnt;
        logic [`ACSPI_DATA_W-1:0] rdata;
    } acspi_regs_t;

endpackage : acspi_pkg

// *** verilog/acspi_sync.sv ***
`timescale 1ns/1ps

module acspi_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } acspi_sync_t;

    acspi_sync_t q;
    acspi_sync_t d;

    // two stages; only the second stage leaves the module
    always_comb begin
        d = q;
        d.meta = d_i;
        d.sync = q.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q.meta <= RST_VAL;
            q.sync <= RST_VAL;
        end else begin
            q <= d;
        end
    end

    assign q_o = q.sync;

endmodule : acspi_sync

// *** verilog/acspi_tick.sv ***
`timescale 1ns/1ps

module acspi_tick #(
    parameter int unsigned CYCLES = 15000
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic tick_o
);

    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    localparam logic [CW-1:0] ONE = CW'(1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } acspi_tick_t;

    acspi_tick_t q;
    acspi_tick_t d;

    // free running divider, one pulse per period
    always_comb begin
        d = q;
        if (q.cnt == LAST) begin
            d.cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + ONE;
            d.tick = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

endmodule : acspi_tick

// *** test/acspi_monitor.sv ***
`timescale 1ns/1ps
module acspi_monitor (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sck_i,
    input wire logic select_n_i,
    input wire logic mosi_i,
    input wire logic miso_o,
    input wire logic miso_oe_o,
    input wire logic selftest_pin_x_i,
    input wire logic selftest_pin_y_i,
    input wire logic selftest_x_o,
    input wire logic selftest_y_o
);
    logic sck_q;
    logic [4:0] cnt_q;
    logic [7:0] cmd_q;
    logic rd_cmd;
    assign rd_cmd = (cmd_q == 8'h08) || (cmd_q == 8'h10) || (cmd_q == 8'h11);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_q <= 1'b0;
            cnt_q <= 5'h00;
            cmd_q <= 8'h00;
        end else begin
            sck_q <= sck_i;
            if (select_n_i) begin
                cnt_q <= 5'h00;
            end else if (sck_i && !sck_q) begin
                cnt_q <= cnt_q + 5'h01;
                if (cnt_q < 5'h08) begin
                    cmd_q <= {cmd_q[6:0], mosi_i};
                end
            end
        end
    end
    default clocking mcb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_oe_first_bit: assert property ($rose(miso_oe_o) |-> cnt_q == 5'h08)
        else $error("miso enable rose away from the ninth bit");
    a_oe_on_fall: assert property ($rose(miso_oe_o) |-> !sck_i && !select_n_i)
        else $error("miso enable rose outside a low clock phase");
    a_miso_on_fall: assert property (miso_oe_o && $past(miso_oe_o) && $changed(miso_o) |-> !sck_i)
        else $error("miso changed while clock high");
    a_oe_release: assert property (select_n_i [*6] |-> !miso_oe_o)
        else $error("miso still driven after deselect");
    a_cmd_quiet: assert property (cnt_q >= 5'h08 && !rd_cmd |-> !miso_oe_o)
        else $error("miso driven after a command with no answer");
    a_oe_after_cmd: assert property (miso_oe_o && !select_n_i |-> cnt_q >= 5'h08)
        else $error("miso driven during the command phase");
    a_stx_hold: assert property ($fell(selftest_x_o) |-> !$past(select_n_i, 2) || !$past(selftest_pin_x_i, 2))
        else $error("x self test dropped without cause");
    a_sty_hold: assert property ($fell(selftest_y_o) |-> !$past(select_n_i, 2) || !$past(selftest_pin_y_i, 2))
        else $error("y self test dropped without cause");
endmodule : acspi_monitor

// *** test/acspi_master.sv ***
`timescale 1ns/1ps
module acspi_master (
    input wire logic clk_i,
    input wire logic miso_i,
    input wire logic miso_oe_i,
    output logic sck_o,
    output logic select_n_o,
    output logic mosi_o
);
    localparam int HALF = 8;
    time nxt [2] = '{0, 0};
    initial begin
        sck_o = 1'b0;
        select_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt
    task automatic xfer(input logic [18:0] b, input int n, output logic [10:0] d);
        int i;
        d = '0;
        if (b[18:12] == 7'h08) begin
            while ($time < nxt[b[11]]) begin
                wt(1);
            end
            nxt[b[11]] = $time + 189000;
        end
        select_n_o <= 1'b0;
        for (i = 0; i < n; i++) begin
            mosi_o <= b[18 - i];
            wt(HALF);
            sck_o <= 1'b1;
            if (i > 7) begin
                d = {d[9:0], miso_oe_i ? miso_i : 1'bz};
            end
            wt(HALF);
            sck_o <= 1'b0;
        end
        wt(HALF);
        select_n_o <= 1'b1;
        mosi_o <= 1'b0;
        wt(1500);
    endtask : xfer
endmodule : acspi_master

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic clk_i, rst_n_i, sck_i, select_n_i, mosi_i, miso_o, miso_oe_o, reg_wr_i, reg_rd_i;
    logic selftest_pin_x_i, selftest_pin_y_i, selftest_x_o, selftest_y_o;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    logic [10:0] d;
    int bad_count, num_checks;
    initial begin
        clk_i = 1'b0;
        forever begin
            #5 clk_i = ~clk_i;
        end
    end
    acspi_top #(.RELOAD_CYCLES(50)) acspi_top_inst (
        .clk_i, .rst_n_i, .sck_i, .select_n_i, .mosi_i, .miso_o, .miso_oe_o, .selftest_pin_x_i,
        .selftest_pin_y_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .selftest_x_o, .selftest_y_o
    );
    acspi_master acspi_master_inst (
        .clk_i, .miso_i(miso_o), .miso_oe_i(miso_oe_o), .sck_o(sck_i), .select_n_o(select_n_i),
        .mosi_o(mosi_i)
    );
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s exp %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        chk(n, reg_rdata_o, e);
        @(posedge clk_i);
    endtask : rchk
    task automatic sx(input string n, input logic [18:0] b, input int len, input logic [31:0] e);
        acspi_master_inst.xfer(b, len, d);
        chk(n, {21'h0, d}, e);
    endtask : sx
    task automatic t_reads;
        chk("mode at reset", {selftest_y_o, selftest_x_o}, 32'h0);
        wr(8'h08, 32'h0000_0123);
        wr(8'h0C, 32'h0000_0050);
        wr(8'h10, 32'h0000_00A5);
        wt(60);
        rchk("unmapped", 8'hFC, 32'h0);
        sx("read x", {8'h10, 11'h0}, 19, 32'h0000_0123);
        sx("read y low", {8'h11, 11'h0}, 19, 32'h0000_0066);
        sx("read temp", {8'h08, 11'h7FF}, 16, 32'h0000_00A5);
    endtask : t_reads
    task automatic t_selftest;
        sx("stx", {8'h0E, 11'h0}, 8, 32'h0);
        chk("st after stx", {selftest_y_o, selftest_x_o}, 32'h1);
        sx("x in test", {8'h10, 11'h0}, 19, 32'h0000_0799);
        sx("measure_cmd", {8'h00, 11'h0}, 8, 32'h0);
        chk("st after measure_cmd", {selftest_y_o, selftest_x_o}, 32'h0);
        selftest_pin_y_i <= 1'b1;
        wt(60);
        chk("st pin y", {selftest_y_o, selftest_x_o}, 32'h2);
        sx("y in test", {8'h11, 11'h0}, 19, 32'h0000_0799);
        selftest_pin_y_i <= 1'b0;
        wt(10);
        sx("sty", {8'h0F, 11'h0}, 8, 32'h0);
        chk("st after sty", {selftest_y_o, selftest_x_o}, 32'h2);
        sx("measure_cmd again", {8'h00, 11'h0}, 8, 32'h0);
        chk("st end", {selftest_y_o, selftest_x_o}, 32'h0);
    endtask : t_selftest
    task automatic t_invalid;
        sx("bad cmd", {8'h55, 11'h7FF}, 19, {21'h0, {11{1'bz}}});
        rchk("counts", 8'h24, 32'h0001_000A);
        sx("cut temp", {8'h08, 11'h0}, 12, 32'h0000_000A);
    endtask : t_invalid
    task automatic t_hold;
        fork
            sx("temp held", {8'h08, 11'h0}, 16, 32'h0000_00A5);
            begin
                wt(20);
                wr(8'h10, 32'h0000_003C);
                wt(20);
                rchk("temp while selected", 8'h20, 32'h0000_00A5);
            end
        join
        rchk("temp after", 8'h20, 32'h0000_003C);
    endtask : t_hold
    task automatic t_faults;
        wr(8'h00, 32'h0000_0001);
        wt(60);
        sx("x link fault", {8'h10, 11'h0}, 19, 32'h0000_07FF);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0000_0001);
        wt(60);
        rchk("cal reloaded", 8'h04, 32'h0);
        wr(8'h04, 32'h0000_0001);
        wt(60);
        sx("y mem fault", {8'h11, 11'h0}, 19, 32'h0);
        rchk("status", 8'h14, 32'h0000_110C);
    endtask : t_faults
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    initial begin
        rst_n_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        selftest_pin_x_i = 1'b0;
        selftest_pin_y_i = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wt(5);
        t_reads;
        t_selftest;
        t_invalid;
        t_hold;
        t_faults;
        final_report;
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        bad_count++;
        final_report;
    end
endmodule : tb_top
bind acspi_top acspi_monitor acspi_monitor_inst (
    .clk_i, .rst_n_i, .sck_i, .select_n_i, .mosi_i, .miso_o, .miso_oe_o, .selftest_pin_x_i,
    .selftest_pin_y_i, .selftest_x_o, .selftest_y_o
);
